// File: rtl/cmx_pkg.sv
// Constants, types and helpers shared by the compat-mode trap unit.
// Assumes a 32-bit classic Wishbone register bus, byte addressed.
package cmx_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL  = 8'h00;
	localparam logic [7:0] ADR_FLAGS = 8'h04;
	localparam logic [7:0] ADR_STAT  = 8'h08;
	localparam logic [7:0] ADR_MASK  = 8'h0c;
	localparam logic [7:0] ADR_IOBM  = 8'h40;
	localparam int         IOBM_WORDS = 8;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_VME_BIT  = 0;
	localparam int FLAGS_VM_BIT  = 17;
	localparam int FLAGS_IO_PRIVILEGE_LEVEL_LO = 12;
	localparam int FLAGS_CPL_LO  = 0;
	localparam int ST_GP         = 0;
	localparam int ST_PF         = 1;
	localparam int ST_EXIT       = 2;
	localparam int ST_PIN        = 3;
	localparam int ST_W          = 4;
	localparam logic [ST_W-1:0] RST_MASK = 4'h0;
	localparam logic [1:0] IO_PRIVILEGE_LEVEL_MAX   = 2'h3;
	localparam logic [1:0] CPL_COMPAT = 2'h3;
	localparam logic [1:0] CPL_REAL   = 2'h0;
	localparam logic [7:0] VEC_GP     = 8'h0d;
	localparam logic [7:0] VEC_PF     = 8'h0e;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE      = 4'h0,
		OP_IF_CLEAR  = 4'h1,
		OP_IF_SET    = 4'h2,
		OP_FLAGS_PSH = 4'h3,
		OP_FLAGS_POP = 4'h4,
		OP_SOFT_INT  = 4'h5,
		OP_INT_RET   = 4'h6,
		OP_HALT      = 4'h7,
		OP_PORT      = 4'h8,
		OP_PORT_STR  = 4'h9,
		OP_MEM       = 4'ha
	} cmx_op_t;

	typedef enum logic [2:0] {
		MD_REAL   = 3'h1,
		MD_PROT   = 3'h2,
		MD_COMPAT = 3'h4
	} cmx_mode_t;

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] cmx_be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction : cmx_be_merge

endpackage : cmx_pkg

// File: rtl/cmx_iobm.sv
// Per-task port permission bitmap held in flip-flops.
// Assumes the loader writes it over the register bus at task switch.
`timescale 1ns/100ps
`default_nettype none
module cmx_iobm #(
	parameter int PORTS = 256
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [2:0]  wr_idx,
	input  wire logic [31:0] wr_data,
	input  wire logic [3:0]  wr_sel,
	input  wire logic [2:0]  rd_idx,
	output logic      [31:0] rd_data,
	input  wire logic [15:0] port,
	output logic             trap
);
	localparam int WORDS = PORTS / 32;

	logic [31:0] map_reg [WORDS];
	wire  [15:0] word_sel = port >> 5;
	wire         in_range = port < 16'(PORTS);

	// Ports beyond the stored map always trap, as an absent map would
	assign trap    = in_range ? map_reg[word_sel[2:0]][port[4:0]] : 1'b1;
	assign rd_data = map_reg[rd_idx];

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < WORDS; i++)
				map_reg[i] <= 32'h0000_0000;
		end
		else if (wr_en)
			map_reg[wr_idx] <= cmx_pkg::cmx_be_merge(map_reg[wr_idx],
				wr_data, wr_sel);
	end
endmodule : cmx_iobm
`default_nettype wire

// File: rtl/cmx_trap.sv
// Mode control and instruction trap decisions for compat mode.
// Assumes the core offers one decoded operation per cycle and stalls
// until the registered verdict (exec, redirect or trap) comes back.
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [RL1] The core runs in compat mode exactly while the compat flag is set.
// [RL2] Compat mode is left only by servicing an interrupt or exception; the code also leaves it on a reset or init pin event.
// [RL3] A suspending hardware interrupt enters protected mode for a switch.
// [RL4] A task switch loads the flags, whose compat flag picks the mode.
// [RL5] Exceptions and owned interrupts go to protected mode; return may resume.
// [RL6] Without the extension a software interrupt leaves via a GP fault; at I/O privilege 3 the code leaves through op_soft_vec.
// [RL7] With the extension set, software interrupts are redirected in place; the code redirects only at I/O privilege 3, below it raises GP.
// [RL8] Reset or init pin in compat mode leaves it for real-address mode.
// [RL9] The halt instruction in compat mode raises a GP fault.
// [RL10] Flag clear/set, flag push/pop, soft interrupt and return are sensitive.
// [RL11] Port instructions in compat mode skip the I/O privilege check.
// [RL12] The current privilege level reads 3 throughout compat mode.
// [RL13] With I/O privilege below 3 a sensitive instruction raises GP.
// [RL14] Compat-mode port accesses always consult the permission bitmap.
// [RL15] A compat-mode access to a not-present page raises an exception.
// [RL16] A GP fault is raised before the faulting instruction changes state.
module cmx_trap #(
	parameter int PORTS = 256
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	input  wire logic             wb_we_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_cyc_i,
	output logic                  wb_ack_o,
	input  wire logic             op_valid,
	input  wire cmx_pkg::cmx_op_t op_code,
	input  wire logic [15:0]      op_port,
	input  wire logic             op_page_present,
	input  wire logic [7:0]       op_soft_vec,
	input  wire logic [1:0]       prot_cpl,
	input  wire logic             ev_valid,
	input  wire logic [7:0]       ev_vec,
	input  wire logic             tsw_valid,
	input  wire logic             tsw_vm,
	input  wire logic [1:0]       tsw_io_privilege_level,
	input  wire logic             ret_valid,
	input  wire logic             ret_vm,
	input  wire logic [1:0]       ret_io_privilege_level,
	input  wire logic             prot_enter,
	input  wire logic             pin_reset,
	input  wire logic             pin_init,
	output logic                  op_exec,
	output logic                  op_redirect,
	output logic                  trap_valid,
	output logic      [7:0]       trap_vec,
	output logic                  compat_mode_flag,
	output logic      [1:0]       io_privilege_level,
	output logic      [1:0]       current_privilege_level,
	output logic                  irq
);
	// ----------------------------------------------------------------
	// Pin synchronisers (reset, init)
	// ----------------------------------------------------------------
	logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
	wire  [1:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
	wire  [1:0] pin_rise  = pin_agree & pin_s3_reg & ~pin_lvl_reg;
	wire        pin_evt   = |pin_rise;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_s1_reg  <= 2'h0;
			pin_s2_reg  <= 2'h0;
			pin_s3_reg  <= 2'h0;
			pin_lvl_reg <= 2'h0;
		end
		else
		begin
			pin_s1_reg  <= {pin_init, pin_reset};
			pin_s2_reg  <= pin_s1_reg;
			pin_s3_reg  <= pin_s2_reg;
			pin_lvl_reg <= (pin_lvl_reg & ~pin_agree) | (pin_s3_reg & pin_agree);
		end
	end

	// ----------------------------------------------------------------
	// Decode of the offered operation
	// ----------------------------------------------------------------
	cmx_pkg::cmx_mode_t mode_reg, mode_next;
	logic [1:0]         io_privilege_level_reg, io_privilege_level_next;
	logic               vme_reg;
	logic               bm_trap;

	wire in_compat = (mode_reg == cmx_pkg::MD_COMPAT);
	wire op_take   = op_valid & ~ev_valid & ~pin_evt;
	wire io_privilege_level_low  = io_privilege_level_reg < cmx_pkg::IO_PRIVILEGE_LEVEL_MAX;
	wire op_sens   = (op_code == cmx_pkg::OP_IF_CLEAR)
	              | (op_code == cmx_pkg::OP_IF_SET)
	              | (op_code == cmx_pkg::OP_FLAGS_PSH)
	              | (op_code == cmx_pkg::OP_FLAGS_POP)
	              | (op_code == cmx_pkg::OP_SOFT_INT)
	              | (op_code == cmx_pkg::OP_INT_RET);          // see [RL10]
	wire op_is_port = (op_code == cmx_pkg::OP_PORT)
	               | (op_code == cmx_pkg::OP_PORT_STR);
	wire op_soft   = (op_code == cmx_pkg::OP_SOFT_INT);
	wire [1:0] cpl_now = in_compat ? cmx_pkg::CPL_COMPAT :      // see [RL12]
	                     (mode_reg == cmx_pkg::MD_PROT) ? prot_cpl :
	                     cmx_pkg::CPL_REAL;
	// Privilege lets a port through only outside compat mode
	wire io_free   = ~in_compat & (cpl_now <= io_privilege_level_reg);      // see [RL11]
	wire gp_port   = op_is_port & ~io_free & bm_trap;           // see [RL14]
	wire gp_sens   = in_compat & op_sens & io_privilege_level_low;            // see [RL13]
	wire gp_halt   = in_compat & (op_code == cmx_pkg::OP_HALT); // see [RL9]
	wire pf_mem    = (op_code == cmx_pkg::OP_MEM) & ~op_page_present; // see [RL15]
	wire soft_redir = in_compat & op_soft & ~io_privilege_level_low & vme_reg;  // see [RL7]
	wire soft_exit  = in_compat & op_soft & ~io_privilege_level_low & ~vme_reg; // see [RL6]
	wire gp_any    = gp_sens | gp_halt | gp_port;
	wire op_fault  = gp_any | pf_mem;
	wire op_leaves = op_take & (op_fault | soft_exit);
	// Faults suppress execution, so no state is touched first
	wire exec_next = op_take & ~op_fault & ~soft_redir & ~soft_exit; // see [RL16]
	wire [7:0] op_vec = gp_any ? cmx_pkg::VEC_GP :
	                    pf_mem ? cmx_pkg::VEC_PF : op_soft_vec;

	// ----------------------------------------------------------------
	// Mode control
	// ----------------------------------------------------------------
	always_comb
	begin
		mode_next = mode_reg;
		io_privilege_level_next = io_privilege_level_reg;
		case (mode_reg)
			cmx_pkg::MD_REAL:
			begin
				if (prot_enter)
					mode_next = cmx_pkg::MD_PROT;
			end
			cmx_pkg::MD_PROT:
			begin
				if (tsw_valid)
				begin
					mode_next = tsw_vm ? cmx_pkg::MD_COMPAT : cmx_pkg::MD_PROT; // see [RL4]
					io_privilege_level_next = tsw_io_privilege_level;
				end
				else if (ret_valid)
				begin
					mode_next = ret_vm ? cmx_pkg::MD_COMPAT : cmx_pkg::MD_PROT; // see [RL5]
					io_privilege_level_next = ret_io_privilege_level;
				end
			end
			cmx_pkg::MD_COMPAT:
			begin
				// Only an interrupt, exception, fault or a reset/init pin event takes the core out
				if (ev_valid || op_leaves)                       // see [RL2]
					mode_next = cmx_pkg::MD_PROT;                // see [RL3]
			end
			default:
				mode_next = cmx_pkg::MD_REAL;
		endcase
		if (pin_evt)
		begin
			mode_next = cmx_pkg::MD_REAL;                        // see [RL8]
			io_privilege_level_next = 2'h0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_reg <= cmx_pkg::MD_REAL;
			io_privilege_level_reg <= 2'h0;
		end
		else
		begin
			mode_reg <= mode_next;
			io_privilege_level_reg <= io_privilege_level_next;
		end
	end

	// ----------------------------------------------------------------
	// Verdict outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			op_exec     <= 1'b0;
			op_redirect <= 1'b0;
			trap_valid  <= 1'b0;
			trap_vec    <= 8'h00;
		end
		else
		begin
			op_exec     <= exec_next;
			op_redirect <= op_take & soft_redir;
			trap_valid  <= ~pin_evt & (ev_valid | op_leaves);
			trap_vec    <= ev_valid ? ev_vec : op_vec;
		end
	end

	assign compat_mode_flag   = in_compat;                     // see [RL1]
	assign io_privilege_level = io_privilege_level_reg;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			current_privilege_level <= cmx_pkg::CPL_REAL;
		else
			current_privilege_level <= (mode_next == cmx_pkg::MD_COMPAT) ?
				cmx_pkg::CPL_COMPAT : (mode_next == cmx_pkg::MD_PROT) ?
				prot_cpl : cmx_pkg::CPL_REAL;                    // see [RL12]
	end

	// ----------------------------------------------------------------
	// Wishbone slave and event status
	// ----------------------------------------------------------------
	logic [cmx_pkg::ST_W-1:0] stat_reg, mask_reg;
	logic [31:0]              bm_rd;

	wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr      = req & wb_we_i;
	wire hit_bm  = (wb_adr_i[7:5] == cmx_pkg::ADR_IOBM[7:5]);
	wire wr_ctrl = wr & (wb_adr_i == cmx_pkg::ADR_CTRL);
	wire wr_stat = wr & (wb_adr_i == cmx_pkg::ADR_STAT) & wb_sel_i[0];
	wire wr_mask = wr & (wb_adr_i == cmx_pkg::ADR_MASK);
	wire [cmx_pkg::ST_W-1:0] st_set;
	assign st_set[cmx_pkg::ST_GP]   = op_take & gp_any & ~pin_evt;
	assign st_set[cmx_pkg::ST_PF]   = op_take & pf_mem & ~pin_evt;
	assign st_set[cmx_pkg::ST_EXIT] = in_compat & (mode_next != cmx_pkg::MD_COMPAT);
	assign st_set[cmx_pkg::ST_PIN]  = pin_evt;
	wire [31:0] flags_rd = (32'(in_compat) << cmx_pkg::FLAGS_VM_BIT)
	                     | (32'(io_privilege_level_reg) << cmx_pkg::FLAGS_IO_PRIVILEGE_LEVEL_LO)
	                     | (32'(current_privilege_level) << cmx_pkg::FLAGS_CPL_LO);
	wire [31:0] rd_mux =
		(wb_adr_i == cmx_pkg::ADR_CTRL)  ? 32'(vme_reg) :
		(wb_adr_i == cmx_pkg::ADR_FLAGS) ? flags_rd :
		(wb_adr_i == cmx_pkg::ADR_STAT)  ? 32'(stat_reg) :
		(wb_adr_i == cmx_pkg::ADR_MASK)  ? 32'(mask_reg) :
		hit_bm                           ? bm_rd : 32'h0000_0000;
	wire [31:0] mask_wr = cmx_pkg::cmx_be_merge(32'(mask_reg), wb_dat_i,
		wb_sel_i);

	cmx_iobm #(
		.PORTS   (PORTS)
	) u_iobm (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.wr_en   (wr & hit_bm),
		.wr_idx  (wb_adr_i[4:2]),
		.wr_data (wb_dat_i),
		.wr_sel  (wb_sel_i),
		.rd_idx  (wb_adr_i[4:2]),
		.rd_data (bm_rd),
		.port    (op_port),
		.trap    (bm_trap)
	);

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			vme_reg  <= 1'b0;
			mask_reg <= cmx_pkg::RST_MASK;
			stat_reg <= '0;
		end
		else
		begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= rd_mux;
			if (wr_ctrl && wb_sel_i[0])
				vme_reg <= wb_dat_i[cmx_pkg::CTRL_VME_BIT];
			if (wr_mask)
				mask_reg <= mask_wr[cmx_pkg::ST_W-1:0];
			// New events win over a clear in the same cycle
			stat_reg <= (stat_reg & ~(wr_stat ? wb_dat_i[cmx_pkg::ST_W-1:0] :
				'0)) | st_set;
		end
	end

	assign irq = |(stat_reg & mask_reg);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	chk_exit_cause: assert property ($fell(compat_mode_flag) |-> // see [RL2]
		$past(ev_valid) || $past(op_leaves) || $past(pin_evt))
		else $error("compat mode left without a cause");
	chk_cpl_three: assert property (compat_mode_flag |->         // see [RL12]
		current_privilege_level == 2'h3)
		else $error("privilege level not 3 in compat mode");
	chk_halt_gp: assert property (op_take && in_compat &&        // see [RL9]
		op_code == cmx_pkg::OP_HALT |=> trap_valid && !op_exec &&
		trap_vec == cmx_pkg::VEC_GP && !compat_mode_flag)
		else $error("halt did not fault");
	chk_sens_gp: assert property (op_take && in_compat && op_sens && // see [RL13]
		io_privilege_level_reg != 2'h3 |=> trap_valid && trap_vec == 8'h0d)
		else $error("sensitive op ran with low io privilege");
	chk_port_free: assert property (op_take && in_compat &&      // see [RL11]
		op_is_port && !bm_trap |=> op_exec && !trap_valid)
		else $error("compat port op blocked without bitmap bit");
	chk_port_map: assert property (op_take && in_compat &&       // see [RL14]
		op_is_port && bm_trap |=> trap_valid ##1 !compat_mode_flag)
		else $error("bitmap bit did not trap");
	chk_page_trap: assert property (op_take && in_compat &&      // see [RL15]
		op_code == cmx_pkg::OP_MEM && !op_page_present
		|=> trap_valid && trap_vec == cmx_pkg::VEC_PF)
		else $error("not-present page did not fault");
	chk_pin_real: assert property (pin_evt |=>                   // see [RL8]
		mode_reg == cmx_pkg::MD_REAL && !compat_mode_flag)
		else $error("pin event did not enter real mode");
	chk_no_exec: assert property (!(op_exec && trap_valid))      // see [RL16]
		else $error("faulting op also executed");
	chk_task_load: assert property (mode_reg == cmx_pkg::MD_PROT && // see [RL4]
		tsw_valid && !pin_evt |=> compat_mode_flag == $past(tsw_vm))
		else $error("task switch flag not loaded");
	chk_redirect: assert property (op_take && in_compat && op_soft && // see [RL7]
		vme_reg && io_privilege_level_reg == 2'h3 |=> op_redirect && compat_mode_flag)
		else $error("soft interrupt not redirected");
endmodule : cmx_trap
`default_nettype wire

// File: tb/cmx_far.sv
// Far-side model: interrupt sources, reset pins and supervisor software.
// Assumes its tasks are called just after a rising edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module cmx_far (
	input  wire logic       clk_sys,
	output logic            ev_valid,
	output logic      [7:0] ev_vec,
	output logic            tsw_valid,
	output logic            ret_valid,
	output logic            fl_vm,
	output logic      [1:0] fl_io_privilege_level,
	output logic            prot_enter,
	output logic            pin_reset,
	output logic            pin_init
);
	initial {ev_valid, ev_vec, tsw_valid, ret_valid, fl_vm, fl_io_privilege_level} = '0;
	initial {prot_enter, pin_reset, pin_init} = '0;
	// Released fields show the inverse, so a stale copy is never trusted
	task automatic fire(input logic [7:0] v);
		ev_vec <= v;
		ev_valid <= 1'b1;
		@(posedge clk_sys);
		ev_valid <= 1'b0;
		ev_vec <= ~v;
	endtask : fire
	// sw=1 task switch, sw=0 handler return; both carry a flags image
	task automatic load(input logic sw, input logic vm, input logic [1:0] pl);
		fl_vm <= vm;
		fl_io_privilege_level <= pl;
		tsw_valid <= sw;
		ret_valid <= !sw;
		@(posedge clk_sys);
		tsw_valid <= 1'b0;
		ret_valid <= 1'b0;
		fl_vm <= !vm;
		fl_io_privilege_level <= ~pl;
	endtask : load
	task automatic prot();
		prot_enter <= 1'b1;
		@(posedge clk_sys);
		prot_enter <= 1'b0;
	endtask : prot
	// Pins are held long enough to pass the input synchroniser
	task automatic pin(input logic init);
		pin_reset <= !init;
		pin_init <= init;
		repeat (6) @(posedge clk_sys);
		pin_reset <= 1'b0;
		pin_init <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask : pin
endmodule : cmx_far
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the compat-mode trap unit.
// Assumes cmx_trap with default PORTS; bus and ops driven at rising edges.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk_sys = 1'b0, rst_b = 1'b0, wb_we_i = 1'b0;
	logic wb_stb_i = 1'b0, wb_cyc_i = 1'b0, op_valid = 1'b0;
	logic [7:0] wb_adr_i = '0, op_soft_vec = '0, ev_vec, trap_vec;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd, rnd;
	logic [3:0] wb_sel_i = '0;
	logic [15:0] op_port = '0;
	logic [1:0] fl_io_privilege_level, io_privilege_level, current_privilege_level;
	logic [1:0] prot_cpl = 2'h0;
	logic op_page_present = 1'b1, wb_ack_o, ev_valid, tsw_valid, ret_valid;
	logic fl_vm, prot_enter, pin_reset, pin_init, op_exec, op_redirect;
	logic trap_valid, compat_mode_flag, irq;
	cmx_pkg::cmx_op_t op_code = cmx_pkg::OP_NONE;
	logic [10:0] exp_q[$];
	int failures = 0, comparisons = 0;

	always #12.5 clk_sys = ~clk_sys;

	cmx_trap u_cmx_trap (.clk_sys, .rst_b, .wb_adr_i, .wb_dat_i, .wb_dat_o,
		.wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .op_valid,
		.op_code, .op_port, .op_page_present, .op_soft_vec,
		.prot_cpl, .ev_valid, .ev_vec, .tsw_valid, .tsw_vm(fl_vm),
		.tsw_io_privilege_level(fl_io_privilege_level), .ret_valid, .ret_vm(fl_vm), .ret_io_privilege_level(fl_io_privilege_level),
		.prot_enter, .pin_reset, .pin_init, .op_exec, .op_redirect,
		.trap_valid, .trap_vec, .compat_mode_flag, .io_privilege_level,
		.current_privilege_level, .irq);
	cmx_far u_far (.clk_sys, .ev_valid, .ev_vec, .tsw_valid, .ret_valid,
		.fl_vm, .fl_io_privilege_level, .prot_enter, .pin_reset, .pin_init);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task automatic check(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Waits for the answer; only the watchdog ends a hung access
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_sys);
	endtask : wb
	function automatic logic [10:0] vd(input int k, input logic [7:0] v);
		return {k == 0, k == 1, k == 2, k == 2 ? v : 8'h00};
	endfunction : vd
	task automatic leave();
		exp_q.push_back(vd(2, 8'h20));
		u_far.fire(8'h20);
		@(posedge clk_sys);
		check("vm after event", compat_mode_flag, 1'b0);
	endtask : leave
	task automatic enter(input logic [1:0] pl);
		if (compat_mode_flag === 1'b1)
			leave();
		u_far.load(1'b0, 1'b1, pl);
		// The new mode is visible only after the edge that loads it
		@(posedge clk_sys);
		check("vm", compat_mode_flag, 1'b1);
		check("cpl", current_privilege_level, 2'h3);
	endtask : enter
	// Op offered in compat mode; any trap must leave compat mode
	task automatic op(input cmx_pkg::cmx_op_t c, input logic [15:0] p,
		input logic pp, input logic [10:0] e);
		op_code <= c;
		op_port <= p;
		op_page_present <= pp;
		op_valid <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys);
		op_valid <= 1'b0;
		@(posedge clk_sys);
		check("vm after op", compat_mode_flag, !e[8]);
	endtask : op

	always @(posedge clk_sys)
		if (rst_b && (op_exec || op_redirect || trap_valid))
			check("verdict", {op_exec, op_redirect, trap_valid,
				trap_valid ? trap_vec : 8'h00},
				exp_q.size() ? exp_q.pop_front() : '1);

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rnd = $urandom(32'h0000_67ac);
		rnd = $urandom;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		prot_cpl <= 2'($urandom_range(3, 0));
		@(posedge clk_sys);
		wb(1'b1, cmx_pkg::ADR_FLAGS, 32'hffff_ffff);
		wb(1'b0, cmx_pkg::ADR_FLAGS, 32'h0000_0000);
		check("flags", rd, 32'h0000_0000);
		wb(1'b0, 8'h30, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		wb(1'b1, cmx_pkg::ADR_MASK, 32'h0000_000f);
		wb(1'b1, cmx_pkg::ADR_IOBM, rnd);
		wb(1'b0, cmx_pkg::ADR_IOBM, 32'h0000_0000);
		check("bitmap", rd, rnd);
		u_far.prot();
		// Each sensitive op at both privilege extremes, extension off
		for (int pl = 0; pl < 4; pl += 3)
			for (int c = 1; c < 7; c++)
			begin
				enter(pl[1:0]);
				op_soft_vec <= 8'h40 + c[7:0];
				op(cmx_pkg::cmx_op_t'(c), 16'h0000, 1'b1,
					pl < 3 ? vd(2, 8'h0d) : c == 5 ? vd(2, 8'h45) :
					vd(0, 8'h00));
			end
		check("irq", irq, 1'b1);
		wb(1'b1, cmx_pkg::ADR_STAT, 32'h0000_000f);
		check("irq clear", irq, 1'b0);
		wb(1'b1, cmx_pkg::ADR_CTRL, 32'h0000_0001);
		enter(2'h3);
		op(cmx_pkg::OP_SOFT_INT, 16'h0000, 1'b1, vd(1, 8'h00));
		enter(2'h1);
		op(cmx_pkg::OP_SOFT_INT, 16'h0000, 1'b1, vd(2, 8'h0d));
		enter(2'h3);
		op(cmx_pkg::OP_HALT, 16'h0000, 1'b1, vd(2, 8'h0d));
		check("io_privilege_level kept", io_privilege_level, 2'h3);
		enter(2'h3);
		op(cmx_pkg::OP_MEM, 16'h0000, 1'b0, vd(2, 8'h0e));
		enter(2'h0);
		op(cmx_pkg::OP_MEM, 16'h0000, 1'b1, vd(0, 8'h00));
		for (int k = 0; k < 10; k++)
		begin
			int p;
			logic [10:0] e;
			p = k == 9 ? 300 : $urandom_range(31, 0);
			e = (p > 31 || rnd[p[4:0]]) ? vd(2, 8'h0d) : vd(0, 8'h00);
			enter($urandom_range(1, 0) ? 2'h3 : 2'h0);
			op(k[0] ? cmx_pkg::OP_PORT : cmx_pkg::OP_PORT_STR, p[15:0], 1'b1,
				e);
		end
		leave();
		u_far.load(1'b1, 1'b0, 2'h2);
		@(posedge clk_sys);
		check("tsw vm0", {compat_mode_flag, io_privilege_level,
			current_privilege_level}, {3'h2, prot_cpl});
		u_far.load(1'b1, 1'b1, 2'h1);
		@(posedge clk_sys);
		check("tsw vm1", {compat_mode_flag, io_privilege_level,
			current_privilege_level}, {3'h5, 2'h3});
		// Event wins over an op offered in the same cycle
		op_code <= cmx_pkg::OP_HALT;
		op_valid <= 1'b1;
		exp_q.push_back(vd(2, 8'h21));
		u_far.fire(8'h21);
		op_valid <= 1'b0;
		@(posedge clk_sys);
		check("vm event", compat_mode_flag, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			u_far.prot();
			enter(2'h3);
			u_far.pin(i[0]);
			check("pin mode", {compat_mode_flag, current_privilege_level},
				3'h0);
		end
		wb(1'b0, cmx_pkg::ADR_STAT, 32'h0000_0000);
		check("pin status", rd & 32'h0000_0008, 32'h0000_0008);
		wb(1'b1, cmx_pkg::ADR_MASK, 32'h0000_0000);
		check("irq masked", irq, 1'b0);
		check("queue empty", exp_q.size(), 32'h0000_0000);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
